/* design/tsc_ctrl.sv */
// test sequence trigger controller with ahb-lite register slave
//
// Function
// (RULE1) start source: key, immediate, lid, bus, ext, line
// (RULE2) one selectable trigger line, default line one
// (RULE3) armed: wait start, release zero check, run
// (RULE4) completion: zero check released, bias standby
// (RULE5) readings stored from buffer location zero
// (RULE6) immediate source starts right after arming
// (RULE7) trigger key also starts except immediate, lid
// (RULE8) sequence indication flashes while armed or running
// (RULE9) alternating test re-arms after each sequence
// (RULE10) first alternating arming forces manual source
// (RULE11) exit key leaves repeating alternating sequence
// (RULE12) basic mode: continuous or single-shot
// (RULE13) basic sources: immediate, key, bus, ext, timer
// (RULE14) timer interval 1 ms to 999999.999 s
// (RULE15) advanced sources add line and hold
// (RULE16) measure delay 1 ms to 999999.999 s
// (RULE17) repeat count infinite or 1 to 99999
// (RULE18) source mode bypasses, bypass_off_mode mode does not
// (RULE19) square wave high/low times, cycles default 10
// (RULE20) alternating discards 3, keeps 1 by default
// (RULE21) surface leakage bias then measure, 50/100 V
// (RULE22) single-shot one measure per event; timer first free
// (RULE23) completion pulse after every measurement
// (RULE24) async inputs synchronised to rising pulses
`timescale 1ns/1ps
module tsc_ctrl
	import tsc_pkg::*;
#(
	parameter int LINES   = 6,  // inter-instrument trigger lines
	parameter int BUF_AW  = 10, // reading buffer address width
	parameter int MS_CYC  = TSC_MS_CYC // cycles per millisecond, shorten for simulation
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire logic              sequence_key,
	input  wire logic              enter_key,
	input  wire logic              trig_key,
	input  wire logic              exit_key,
	input  wire logic              bus_trigger,
	input  wire logic              ext_trigger,
	input  wire logic [LINES-1:0]  intercon_trigger_line,
	input  wire logic              fixture_lid_shut,
	input  wire logic              meas_done,
	output logic                   meas_start,
	output logic                   zero_check,
	output logic                   bias_standby,
	output logic                   seq_indicator,
	output logic                   meter_complete,
	output logic                   buf_wr,
	output logic      [BUF_AW-1:0] buf_addr
);
	localparam int NIN = LINES + 7;

	// synchronised inputs
	logic [NIN-1:0] sync_lvl;
	logic [NIN-1:0] sync_rise;
	tsc_edge_sync #(.W(NIN)) u_sync (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.async_in ({intercon_trigger_line, fixture_lid_shut, ext_trigger, bus_trigger,
		            exit_key, trig_key, enter_key, sequence_key}),
		.level    (sync_lvl),
		.rise     (sync_rise)
	);
	logic             seq_ev, enter_ev, trig_ev, exit_ev, bus_ev, ext_ev, lid_ev;
	logic [LINES-1:0] line_ev;
	assign {line_ev, lid_ev, ext_ev, bus_ev, exit_ev, trig_ev, enter_ev, seq_ev} = sync_rise;

	// registers
	logic        seq_arm_req;   // software arm request pulse
	logic [1:0]  test_sel;      // selected test
	logic [2:0]  start_src;     // start source
	logic [2:0]  line_sel;      // trigger line index
	logic        adv_mode;      // 0 basic, 1 advanced
	logic        one_shot;      // basic single-shot mode
	logic [2:0]  meas_src;      // measure trigger source
	logic        bypass_off_mode; // bypass_off_mode mode: no source bypass
	logic        infinite;      // repeat forever
	logic        trig_enable;   // measurement model running
	logic [39:0] interval_ms;
	logic [39:0] delay_ms;
	logic [16:0] measure_repeat_count;
	logic [15:0] cycle_count;
	logic [7:0]  readings_discarded;
	logic [7:0]  readings_kept;
	logic [15:0] bias_level;
	logic [15:0] measure_level;
	logic        alt_first;     // first arming of alternating test pending

	// ahb-lite address phase capture
	logic        dp_wr, dp_rd;
	logic [7:0]  dp_addr;
	logic        ahb_go;
	assign ahb_go = hsel && hready && htrans[1];

	// capture address phase; zero wait states, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr <= 1'b0;
			dp_rd <= 1'b0;
			dp_addr <= 8'h00;
		end else begin
			dp_wr <= ahb_go && hwrite;
			dp_rd <= ahb_go && !hwrite;
			dp_addr <= haddr[7:0];
		end
	end

	// clamp a millisecond value into the documented span
	function automatic logic [39:0] clamp_ms(input logic [39:0] v);
		if (v < TSC_MS_MIN) return TSC_MS_MIN;
		if (v > TSC_MS_MAX) return TSC_MS_MAX;
		return v;
	endfunction

	// sequence state
	tsc_state_t state;
	logic       running;
	logic       start_hit;

	// register writes; arming the alternating test the first time forces manual
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			test_sel <= TSC_TEST_SQUARE;
			start_src <= TSC_SRC_MANUAL;   // [RULE1]
			line_sel <= TSC_LINE_DEFAULT; // [RULE2]
			adv_mode <= 1'b0;
			one_shot <= 1'b0;
			meas_src <= TSC_MSRC_IMMEDIATE;
			bypass_off_mode <= 1'b0;
			infinite <= 1'b1;
			trig_enable <= 1'b0;
			interval_ms <= TSC_MS_MIN;
			delay_ms <= TSC_MS_MIN;
			measure_repeat_count <= TSC_CNT_MIN;
			cycle_count <= TSC_CYCLES_DEFAULT;   // [RULE19]
			readings_discarded <= TSC_DISCARD_DEFAULT; // [RULE20]
			readings_kept <= TSC_KEEP_DEFAULT;       // [RULE20]
			bias_level <= TSC_BIAS_V_DEFAULT;        // [RULE21]
			measure_level <= TSC_MEAS_V_DEFAULT;     // [RULE21]
			seq_arm_req <= 1'b0;
			alt_first <= 1'b1;
		end else begin
			seq_arm_req <= 1'b0;
			if (state == TSC_IDLE && test_sel == TSC_TEST_ALTPOL && alt_first &&
			    (enter_ev || seq_arm_req)) begin
				start_src <= TSC_SRC_MANUAL; // [RULE10]
				alt_first <= 1'b0;
			end else if (exit_ev && state == TSC_ARMED) begin
				alt_first <= 1'b1; // next alternating arming forces manual again
			end
			if (dp_wr) begin
				case (dp_addr)
				TSC_REG_SEQ_CTRL: begin
					test_sel <= hwdata[1:0];
					start_src <= (hwdata[4:2] > TSC_SRC_LINE) ? TSC_SRC_MANUAL : hwdata[4:2];
					line_sel <= (32'(hwdata[7:5]) < LINES) ? hwdata[7:5] : TSC_LINE_DEFAULT;
					seq_arm_req <= hwdata[8];
					if (hwdata[1:0] != test_sel)
						alt_first <= 1'b1;
				end
				TSC_REG_TRIG_CTRL: begin
					adv_mode <= hwdata[0];
					one_shot <= hwdata[1];             // [RULE12]
					meas_src <= hwdata[4:2];           // [RULE13] [RULE15]
					bypass_off_mode <= hwdata[5];      // [RULE18]
					infinite <= hwdata[6];             // [RULE17]
					trig_enable <= hwdata[7];
				end
				TSC_REG_INTERVAL: interval_ms <= clamp_ms({8'h00, hwdata}); // [RULE14]
				TSC_REG_DELAY: delay_ms <= clamp_ms({8'h00, hwdata});       // [RULE16]
				TSC_REG_COUNT: begin
					if (hwdata[16:0] < TSC_CNT_MIN)
						measure_repeat_count <= TSC_CNT_MIN;
					else if (hwdata[16:0] > TSC_CNT_MAX)
						measure_repeat_count <= TSC_CNT_MAX; // [RULE17]
					else
						measure_repeat_count <= hwdata[16:0];
				end
				TSC_REG_TEST_PARAM: begin
					cycle_count <= hwdata[15:0];
					readings_discarded <= hwdata[23:16];
					readings_kept <= hwdata[31:24];
				end
				TSC_REG_LEVELS: begin
					bias_level <= hwdata[15:0];
					measure_level <= hwdata[31:16];
				end
				default: ;
				endcase
			end
		end
	end

	// start event selection, trigger key also valid for most sources
	always_comb begin
		case (start_src)
		TSC_SRC_MANUAL:    start_hit = trig_ev;
		TSC_SRC_IMMEDIATE: start_hit = 1'b1;                  // [RULE6]
		TSC_SRC_LID:       start_hit = lid_ev;
		TSC_SRC_BUS:       start_hit = bus_ev || trig_ev;     // [RULE7]
		TSC_SRC_EXT:       start_hit = ext_ev || trig_ev;     // [RULE7]
		TSC_SRC_LINE:      start_hit = line_ev[line_sel] || trig_ev; // [RULE2] [RULE7]
		default:           start_hit = trig_ev;
		endcase
	end

	// millisecond tick divider
	logic [31:0] ms_div;
	logic        ms_tick;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ms_div <= 32'h0;
			ms_tick <= 1'b0;
		end else begin
			ms_tick <= (ms_div == 32'(MS_CYC - 1));
			ms_div <= (ms_div == 32'(MS_CYC - 1)) ? 32'h0 : ms_div + 32'h1;
		end
	end

	// test phase timer: square high/low halves, sir bias/measure, alt readings
	logic [39:0] phase_ms;   // ms left in phase
	logic [15:0] cyc_left;   // square half-periods left
	logic [7:0]  rdg_cnt;    // alternating readings taken
	logic [1:0]  phase;      // 0 high/bias, 1 low/measure
	logic        test_end;
	assign test_end = running && phase_ms == 40'h0 && ms_tick &&
	                  ((test_sel == TSC_TEST_SQUARE && cyc_left <= 16'h1) ||
	                   (test_sel == TSC_TEST_SIR && phase == 2'h1) ||
	                   (test_sel == TSC_TEST_ALTPOL &&
	                    rdg_cnt + 8'h1 >= readings_discarded + readings_kept));

	// sequence state machine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= TSC_IDLE;
		end else begin
			case (state)
			TSC_IDLE: if (enter_ev || seq_arm_req) state <= TSC_ARMED; // [RULE3]
			TSC_ARMED:
				if (exit_ev) state <= TSC_IDLE;                  // [RULE11]
				else if (start_hit) state <= TSC_RUN;            // [RULE3] [RULE6]
			TSC_RUN: if (test_end) state <= TSC_DONE;
			TSC_DONE:
				if (test_sel == TSC_TEST_ALTPOL) state <= TSC_ARMED; // [RULE9]
				else state <= TSC_IDLE;
			default: state <= TSC_IDLE;
			endcase
		end
	end
	assign running = (state == TSC_RUN);

	// test phase counters
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_ms <= 40'h0;
			cyc_left <= 16'h0;
			rdg_cnt <= 8'h0;
			phase <= 2'h0;
		end else if (state == TSC_ARMED) begin
			phase_ms <= interval_ms - 40'h1;
			cyc_left <= (cycle_count == 16'h0) ? 16'h1 : cycle_count << 1; // [RULE19]
			rdg_cnt <= 8'h0;
			phase <= 2'h0;
		end else if (running && ms_tick) begin
			if (phase_ms != 40'h0) begin
				phase_ms <= phase_ms - 40'h1;
			end else begin
				phase_ms <= interval_ms - 40'h1;
				phase <= phase ^ 2'h1;                          // [RULE19] [RULE21]
				cyc_left <= cyc_left - 16'h1;
				rdg_cnt <= rdg_cnt + 8'h1;                      // [RULE20]
			end
		end
	end

	// zero check and bias standby: released at start, standby at end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			zero_check <= 1'b1;
			bias_standby <= 1'b1;
		end else if (state == TSC_ARMED && start_hit && !exit_ev) begin
			zero_check <= 1'b0;   // [RULE3]
			bias_standby <= 1'b0;
		end else if (state == TSC_DONE) begin
			bias_standby <= 1'b1; // [RULE4] zero check stays released
		end
	end

	// flashing indication: ~2 Hz blink from the ms tick, toggling every 256 ms
	logic [7:0] blink_ms;
	logic       blink;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			blink_ms <= 8'h0;
			blink <= 1'b0;
			seq_indicator <= 1'b0;
		end else begin
			if (ms_tick) blink_ms <= blink_ms + 8'h1;
			if (ms_tick && blink_ms == 8'hff) blink <= ~blink;
			seq_indicator <= (state != TSC_IDLE) && !blink; // [RULE8]
		end
	end

	// measurement trigger model
	logic        meas_pend;    // waiting for engine
	logic        delaying;
	logic [39:0] dly_left;
	logic [39:0] tmr_left;
	logic        tmr_first;
	logic [16:0] meas_done_cnt;
	logic        meas_ev;
	logic        seq_meas;     // test wants a reading
	assign seq_meas = running && ms_tick && phase_ms == 40'h0 &&
	                  (test_sel != TSC_TEST_SIR || phase == 2'h1);
	always_comb begin
		case (meas_src)
		TSC_MSRC_IMMEDIATE: meas_ev = 1'b1;
		TSC_MSRC_KEY:       meas_ev = trig_ev;
		TSC_MSRC_BUS:       meas_ev = bus_ev;
		TSC_MSRC_EXT:       meas_ev = ext_ev;
		TSC_MSRC_TIMER:     meas_ev = tmr_first || tmr_left == 40'h0; // [RULE22]
		TSC_MSRC_LINE:      meas_ev = adv_mode && line_ev[line_sel];  // [RULE15]
		TSC_MSRC_HOLD:      meas_ev = 1'b0;                          // [RULE15]
		default:            meas_ev = 1'b0;
		endcase
		if (!one_shot && !adv_mode)
			meas_ev = 1'b1; // continuous mode [RULE12]
		if (adv_mode && !bypass_off_mode && tmr_first && meas_src != TSC_MSRC_HOLD)
			meas_ev = 1'b1; // source bypass on the first pass [RULE18]
	end

	// measure layer: event, delay, start, count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meas_pend <= 1'b0;
			delaying <= 1'b0;
			dly_left <= 40'h0;
			tmr_left <= 40'h0;
			tmr_first <= 1'b1;
			meas_done_cnt <= 17'h0;
			meas_start <= 1'b0;
		end else begin
			meas_start <= 1'b0;
			if (ms_tick && tmr_left != 40'h0) tmr_left <= tmr_left - 40'h1;
			if (!trig_enable && !running) begin
				tmr_first <= 1'b1;
				meas_done_cnt <= 17'h0;
				delaying <= 1'b0;
			end else if (seq_meas && !meas_pend) begin
				meas_start <= 1'b1;
				meas_pend <= 1'b1;
			end else if (!meas_pend && !delaying && meas_ev && !running &&
			             (infinite || meas_done_cnt < measure_repeat_count)) begin
				tmr_first <= 1'b0;
				tmr_left <= interval_ms;                // [RULE14]
				delaying <= adv_mode;
				dly_left <= delay_ms;                   // [RULE16]
				if (!adv_mode) begin
					meas_start <= 1'b1;                 // [RULE22]
					meas_pend <= 1'b1;
				end
			end else if (delaying && ms_tick) begin
				if (dly_left <= 40'h1) begin
					delaying <= 1'b0;
					meas_start <= 1'b1;
					meas_pend <= 1'b1;
				end else
					dly_left <= dly_left - 40'h1;
			end
			if (meas_pend && meas_done) begin
				meas_pend <= 1'b0;
				if (!infinite) meas_done_cnt <= meas_done_cnt + 17'h1; // [RULE17]
			end
		end
	end

	// completion pulse after each measurement; buffer write only for kept readings while running
	logic [7:0] pulse_cnt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pulse_cnt <= 8'h0;
			meter_complete <= 1'b0;
			buf_wr <= 1'b0;
			buf_addr <= '0;
		end else begin
			buf_wr <= 1'b0;
			if (state == TSC_ARMED && start_hit)
				buf_addr <= '0;                          // [RULE5]
			else if (buf_wr)
				buf_addr <= buf_addr + 1'b1;
			if (meas_pend && meas_done) begin
				pulse_cnt <= 8'(TSC_PULSE_CYC);
				meter_complete <= 1'b1;                  // [RULE23]
				buf_wr <= running && (test_sel != TSC_TEST_ALTPOL ||
				          rdg_cnt >= readings_discarded); // [RULE5] [RULE20]
			end else if (pulse_cnt > 8'h1) begin
				pulse_cnt <= pulse_cnt - 8'h1;
			end else begin
				pulse_cnt <= 8'h0;
				meter_complete <= 1'b0;
			end
		end
	end

	// read mux and bus answer, registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (ahb_go && !hwrite) begin
				case (haddr[7:0])
				TSC_REG_SEQ_CTRL: hrdata <= {23'h0, 1'b0, line_sel, start_src, test_sel};
				TSC_REG_TRIG_CTRL: hrdata <= {24'h0, trig_enable, infinite,
				                              bypass_off_mode, meas_src, one_shot, adv_mode};
				TSC_REG_INTERVAL: hrdata <= interval_ms[31:0];
				TSC_REG_DELAY: hrdata <= delay_ms[31:0];
				TSC_REG_COUNT: hrdata <= {15'h0, measure_repeat_count};
				TSC_REG_TEST_PARAM: hrdata <= {readings_kept, readings_discarded, cycle_count};
				TSC_REG_STATUS: hrdata <= {16'h0, buf_addr[7:0], 1'b0, meas_pend, zero_check,
				                           state};
				TSC_REG_LEVELS: hrdata <= {measure_level, bias_level};
				default: hrdata <= 32'h0;
				endcase
			end
		end
	end

	a_arm_start : assert property (@(posedge hclk) disable iff (!hresetn)
		(state == TSC_ARMED && start_hit && !exit_ev) |=> (state == TSC_RUN && !zero_check))
		else $error("start event did not run test"); // [RULE3]
	a_done_standby : assert property (@(posedge hclk) disable iff (!hresetn)
		(state == TSC_DONE) |=> (bias_standby && !zero_check))
		else $error("no standby after test"); // [RULE4]
	a_imm_start : assert property (@(posedge hclk) disable iff (!hresetn)
		(state == TSC_ARMED && start_src == TSC_SRC_IMMEDIATE && !exit_ev) |=> running)
		else $error("immediate start waited"); // [RULE6]
	a_key_start : assert property (@(posedge hclk) disable iff (!hresetn)
		(state == TSC_ARMED && trig_ev && start_src != TSC_SRC_LID) |-> start_hit)
		else $error("trigger key ignored"); // [RULE7]
	a_alt_rearm : assert property (@(posedge hclk) disable iff (!hresetn)
		(state == TSC_DONE && test_sel == TSC_TEST_ALTPOL) |=> state == TSC_ARMED)
		else $error("alternating test not re-armed"); // [RULE9]
	a_exit_leave : assert property (@(posedge hclk) disable iff (!hresetn)
		(state == TSC_ARMED && exit_ev) |=> state == TSC_IDLE)
		else $error("exit ignored"); // [RULE11]
	a_hold_stall : assert property (@(posedge hclk) disable iff (!hresetn)
		(adv_mode && meas_src == TSC_MSRC_HOLD && !meas_pend && !delaying && !running)
		|=> !meas_start) else $error("hold source measured"); // [RULE15]
	a_complete_pulse : assert property (@(posedge hclk) disable iff (!hresetn)
		(meas_pend && meas_done) |=> meter_complete [*2])
		else $error("completion pulse missing"); // [RULE23]
	a_buf_zero : assert property (@(posedge hclk) disable iff (!hresetn)
		(state == TSC_ARMED && start_hit) |=> buf_addr == '0)
		else $error("buffer not at zero"); // [RULE5]
	a_flash_idle : assert property (@(posedge hclk) disable iff (!hresetn)
		(state == TSC_IDLE) [*2] |-> !seq_indicator)
		else $error("indicator while idle"); // [RULE8]
	c_run_test : cover property (@(posedge hclk) disable iff (!hresetn)
		state == TSC_ARMED ##1 state == TSC_RUN);
	c_alt_loop : cover property (@(posedge hclk) disable iff (!hresetn)
		state == TSC_DONE && test_sel == TSC_TEST_ALTPOL);
	c_meas_done : cover property (@(posedge hclk) disable iff (!hresetn)
		meas_pend && meas_done);
endmodule

/* design/tsc_pkg.sv */
// package of constants, register map and types for the test sequence trigger controller
package tsc_pkg;
	// register byte offsets (aligned words)
	localparam logic [7:0] TSC_REG_SEQ_CTRL   = 8'h00; // test select, start source, arm
	localparam logic [7:0] TSC_REG_TRIG_CTRL  = 8'h04; // basic/advanced trigger setup
	localparam logic [7:0] TSC_REG_INTERVAL   = 8'h08; // timer interval, ms
	localparam logic [7:0] TSC_REG_DELAY      = 8'h0c; // measure-layer delay, ms
	localparam logic [7:0] TSC_REG_COUNT      = 8'h10; // measure repeat count
	localparam logic [7:0] TSC_REG_TEST_PARAM = 8'h14; // cycle count / discard / keep
	localparam logic [7:0] TSC_REG_STATUS     = 8'h18; // read-only state
	localparam logic [7:0] TSC_REG_LEVELS     = 8'h1c; // bias / measure levels, volts
	// start sources for an armed test
	localparam logic [2:0] TSC_SRC_MANUAL    = 3'h0;
	localparam logic [2:0] TSC_SRC_IMMEDIATE = 3'h1;
	localparam logic [2:0] TSC_SRC_LID       = 3'h2;
	localparam logic [2:0] TSC_SRC_BUS       = 3'h3;
	localparam logic [2:0] TSC_SRC_EXT       = 3'h4;
	localparam logic [2:0] TSC_SRC_LINE      = 3'h5;
	// measurement trigger sources (basic uses the first five)
	localparam logic [2:0] TSC_MSRC_IMMEDIATE = 3'h0;
	localparam logic [2:0] TSC_MSRC_KEY       = 3'h1;
	localparam logic [2:0] TSC_MSRC_BUS       = 3'h2;
	localparam logic [2:0] TSC_MSRC_EXT       = 3'h3;
	localparam logic [2:0] TSC_MSRC_TIMER     = 3'h4;
	localparam logic [2:0] TSC_MSRC_LINE      = 3'h5;
	localparam logic [2:0] TSC_MSRC_HOLD      = 3'h6;
	// tests
	localparam logic [1:0] TSC_TEST_SQUARE = 2'h0;
	localparam logic [1:0] TSC_TEST_ALTPOL = 2'h1;
	localparam logic [1:0] TSC_TEST_SIR    = 2'h2;
	// reset values
	localparam logic [2:0]  TSC_LINE_DEFAULT   = 3'h0; // line one
	localparam logic [15:0] TSC_CYCLES_DEFAULT = 16'h000a;
	localparam logic [7:0]  TSC_DISCARD_DEFAULT = 8'h03;
	localparam logic [7:0]  TSC_KEEP_DEFAULT    = 8'h01;
	localparam logic [15:0] TSC_BIAS_V_DEFAULT  = 16'h0032; // +50 V
	localparam logic [15:0] TSC_MEAS_V_DEFAULT  = 16'h0064; // +100 V
	localparam logic [39:0] TSC_MS_MIN   = 40'h00_0000_0001; // 0.001 s
	localparam logic [39:0] TSC_MS_MAX   = 40'h00_3b9a_c9ff; // 999999.999 s
	localparam logic [16:0] TSC_CNT_MAX  = 17'h1869f;        // 99999
	localparam logic [16:0] TSC_CNT_MIN  = 17'h00001;
	// timing
	localparam int TSC_CLK_HZ   = 100_000_000;
	localparam int TSC_MS_CYC   = TSC_CLK_HZ / 1000; // cycles per millisecond
	localparam int TSC_PULSE_NS = 100;               // completion pulse width
	localparam int TSC_PULSE_CYC = (TSC_PULSE_NS * (TSC_CLK_HZ / 1_000_000) + 999) / 1000;
	// sequence state machine
	typedef enum logic [4:0] {
		TSC_IDLE  = 5'b00001,
		TSC_ARMED = 5'b00010,
		TSC_RUN   = 5'b00100,
		TSC_MEAS  = 5'b01000,
		TSC_DONE  = 5'b10000
	} tsc_state_t;
endpackage

/* design/tsc_edge_sync.sv */
// two-flop synchroniser with rising-event pulse
`timescale 1ns/1ps
module tsc_edge_sync
	import tsc_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise
);
	logic [W-1:0] meta; // first flop, read only by level
	logic [W-1:0] prev; // previous synced level

	// synchronise and detect rising edges, one pulse per event [RULE24]
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta <= '0;
			level <= '0;
			prev <= '0;
		end else begin
			meta <= async_in;
			level <= meta;
			prev <= level;
		end
	end
	assign rise = level & ~prev; // [RULE24]

	a_rise_single : assert property (@(posedge hclk) disable iff (!hresetn)
		|rise |=> ((rise & $past(rise)) == '0)) else $error("double rise pulse"); // [RULE24]
endmodule

/* tb/tsc_keys_model.sv */
// partner model: operator keys, trigger inputs and the measure engine
`timescale 1ns/1ps
module tsc_keys_model (
	input  wire logic        hclk,
	input  wire logic        meas_start,
	output logic      [12:0] ev,
	output logic             meas_done
);
	int lat = 3; // engine answer time in cycles, raised for a slow engine
	initial begin
		ev = '0;
		meas_done = 1'b0;
	end
	// one press, held long enough for the input synchroniser to see it
	task automatic press(input int i);
		@(posedge hclk);
		ev[i] <= 1'b1;
		repeat (6) @(posedge hclk);
		ev[i] <= 1'b0;
	endtask
	// engine answers each start with a one-cycle done pulse
	always @(posedge hclk) begin
		if (meas_start === 1'b1) begin
			repeat (lat) @(posedge hclk);
			meas_done <= 1'b1;
			@(posedge hclk);
			meas_done <= 1'b0;
		end
	end
endmodule

/* tb/tsc_ctrl_bench.sv */
// self-checking bench for the test sequence trigger controller
`timescale 1ns/1ps
module tsc_ctrl_bench;
	import tsc_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic        meas_start, meas_done, zero_check, bias_standby;
	logic [12:0] ev;  // 0 trig,1 exit,2 bus,3 ext,4 lid,5 enter,6 seq,7.. lines
	logic [9:0]  buf_addr;
	int          fail_count, n_tests, cyc;
	int          n_ms, n_wr, n_mc, w0; // starts, buffer writes, completion pulses seen
	logic        seq_ind, mc, mc_d, buf_wr;
	initial begin
		hclk = 0;
		forever #5 hclk = ~hclk;
	end
	tsc_keys_model u_keys (.hclk(hclk), .meas_start(meas_start), .ev(ev),
		.meas_done(meas_done));
	tsc_ctrl #(.MS_CYC(10)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.sequence_key(ev[6]), .enter_key(ev[5]), .trig_key(ev[0]), .exit_key(ev[1]),
		.bus_trigger(ev[2]), .ext_trigger(ev[3]), .intercon_trigger_line(ev[12:7]),
		.fixture_lid_shut(ev[4]), .meas_done(meas_done), .meas_start(meas_start),
		.zero_check(zero_check), .bias_standby(bias_standby), .seq_indicator(seq_ind),
		.meter_complete(mc), .buf_wr(buf_wr), .buf_addr(buf_addr));
	// count measurement starts, buffer writes and completion pulses for the checks
	always @(posedge hclk) begin
		n_ms += (meas_start === 1'b1);
		n_wr += (buf_wr === 1'b1);
		n_mc += (mc === 1'b1 && mc_d !== 1'b1);
		mc_d <= mc;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// one single word transfer; hready is the slave's own ready
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// bounded wait for the bias supply level, then judge it
	task wait_bs(input logic v);
		repeat (20000) if (bias_standby !== v) @(posedge hclk);
		chk({31'h0, bias_standby}, {31'h0, v});
	endtask
	// arm one square test on a source; fire its event if it needs one
	task run_src(input logic [2:0] src, input logic [2:0] ln, input int e);
		ahb(1, TSC_REG_SEQ_CTRL, {23'h0, 1'b1, ln, src, 2'b00});
		w0 = n_wr;
		if (e >= 0) begin
			ahb(0, TSC_REG_STATUS, 0);
			chk(rd[4:0], 5'h02); // waiting while armed
			u_keys.press(e);
		end
		wait_bs(1'b0);
		chk({22'h0, buf_addr}, 32'h0);
		chk({31'h0, zero_check}, 32'h0);
		wait_bs(1'b1);
		chk({31'h0, zero_check}, 32'h0);
		chk({22'h0, buf_addr}, 32'h1);
		chk(n_wr - w0, 1);
	endtask
	task t_reset;
		ahb(0, TSC_REG_STATUS, 0);
		chk(rd, 32'h21); // idle, zero check on
		ahb(0, TSC_REG_SEQ_CTRL, 0);
		chk(rd, 32'h0); // manual, line one
		ahb(0, TSC_REG_TEST_PARAM, 0);
		chk(rd, 32'h0103000a);
		ahb(0, TSC_REG_LEVELS, 0);
		chk(rd, 32'h00640032);
		ahb(0, 8'h40, 0);
		chk(rd, 32'h0); // unmapped place reads zero
		ahb(1, TSC_REG_TEST_PARAM, 32'h01030001);
	endtask
	// repeating alternating test with a slow engine
	task t_alt;
		u_keys.lat = 40;
		ahb(1, TSC_REG_SEQ_CTRL, 32'h105);
		ahb(0, TSC_REG_STATUS, 0);
		chk(rd[4:0], 5'h02); // immediate forced to manual
		ahb(0, TSC_REG_SEQ_CTRL, 0);
		chk(rd[4:2], 3'h0);
		u_keys.press(0);
		wait_bs(1'b0);
		wait_bs(1'b1);
		repeat (4) @(posedge hclk);
		ahb(0, TSC_REG_STATUS, 0);
		chk(rd[4:0], 5'h02);
		repeat (3000) if (seq_ind !== 1'b1) @(posedge hclk);
		chk({31'h0, seq_ind}, 32'h1);
		u_keys.press(1);
		repeat (4) @(posedge hclk);
		ahb(0, TSC_REG_STATUS, 0);
		chk(rd[4:0], 5'h01);
		chk({31'h0, seq_ind}, 32'h0);
	endtask
	// measure layer while idle: hold stalls, one-shot key gives one reading
	task t_meas;
		int m0;
		int c0;
		m0 = n_ms;
		ahb(1, TSC_REG_TRIG_CTRL, 32'hd9);
		repeat (200) @(posedge hclk);
		chk(n_ms - m0, 0);
		ahb(1, TSC_REG_TRIG_CTRL, 32'hc6);
		c0 = n_mc;
		u_keys.press(0);
		repeat (100) @(posedge hclk);
		chk(n_ms - m0, 1);
		chk(n_mc - c0, 1);
		ahb(1, TSC_REG_TRIG_CTRL, 32'h0);
		ahb(1, TSC_REG_COUNT, 32'h0);
		ahb(0, TSC_REG_COUNT, 0);
		chk(rd, 32'h1);
		ahb(1, TSC_REG_DELAY, 32'hffffffff);
		ahb(0, TSC_REG_DELAY, 0);
		chk(rd, 32'h3b9ac9ff);
		ahb(1, TSC_REG_INTERVAL, 32'h0);
		ahb(0, TSC_REG_INTERVAL, 0);
		chk(rd, 32'h1);
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 90000) begin
			fail_count++;
			results;
		end
	end
	initial begin
		hresetn = 0;
		hsel = 0;
		hwrite = 0;
		haddr = 0;
		hwdata = 0;
		htrans = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		run_src(TSC_SRC_IMMEDIATE, 0, -1);
		run_src(TSC_SRC_MANUAL, 0, 0);
		run_src(TSC_SRC_BUS, 0, 2);
		run_src(TSC_SRC_BUS, 0, 0);
		run_src(TSC_SRC_EXT, 0, 3);
		run_src(TSC_SRC_LID, 0, 4);
		run_src(TSC_SRC_LINE, 0, 7);
		run_src(TSC_SRC_LINE, 2, 9);
		t_alt;
		t_meas;
		results;
	end
endmodule
